// ---- test/mazf_seq_src.sv ----
// Converter sequencer model offering queued samples on the valid/ready stream
`timescale 1ns/1ps
module mazf_seq_src
  import mazf_pkg::*;
(
  input  wire logic              core_clk,  // Clock
  input  wire logic              rst_n,     // Sync reset, low
  input  wire logic              smp_ready, // Sample taken
  output logic                   smp_valid, // Sample offered
  output logic      [DATA_W-1:0] smp_data,  // Sample value
  output logic      [2:0]        smp_chan   // Sample channel
);
  logic [14:0] q[$];
  // ==========================================================
  // Offer held until taken; value scrambled while idle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      smp_valid <= 1'b0;
      smp_data  <= 12'h5A5;
      smp_chan  <= 3'h0;
    end else if (!smp_valid || smp_ready) begin
      if (q.size() > 0) begin
        smp_valid              <= 1'b1;
        {smp_chan, smp_data}   <= q.pop_front();
      end else begin
        smp_valid <= 1'b0;
        smp_data  <= ~smp_data;
      end
    end
  end
endmodule : mazf_seq_src

// ---- test/tb_median_average_zone_filter.sv ----
// Testbench: filter modes and zone alerts against a queue model
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_median_average_zone_filter;
  import mazf_pkg::*;
  logic              core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0]        avs_address    = 6'h00;
  logic [31:0]       avs_writedata  = 32'h0000_0000, avs_readdata, q;
  logic [3:0]        avs_byteenable = 4'hF;
  logic              avs_waitrequest, smp_valid, smp_ready, res_valid, hit;
  logic              touch_or_ready_alert_pin_n;
  logic [DATA_W-1:0] smp_data, res_data, e;
  logic [2:0]        smp_chan, res_chan, ch;
  int                fails = 0, checks = 0, n, v, s[$];
  int                vals[6] = '{255, 256, 257, 511, 512, 513};
  logic [2:0]        chs[4]  = '{CH_AUX, CH_TSNGL, CH_TDIFF, CH_X};
  mazf_top i_dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .smp_valid, .smp_data, .smp_chan,
    .smp_ready, .res_valid, .res_data, .res_chan, .touch_or_ready_alert_pin_n);
  mazf_seq_src i_src (.core_clk, .rst_n, .smp_ready, .smp_valid, .smp_data, .smp_chan);
  initial forever #20 core_clk = ~core_clk;
  // ==========================================================
  // Tasks
  task test_done;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin fails++; test_done(); end
    @(posedge core_clk);
  endtask : bus
  task wait_res;
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      if (res_valid === 1'b1) break;
    end
    if (i == 3000) begin fails++; test_done(); end
  endtask : wait_res
  // Sort, then median, average, or middle average with the median counted twice
  function automatic int model(int m, int w, int x[$]);
    int mid, acc, h;
    x.sort();
    if (m == 0) return x.sum() >> (w == 0 ? 0 : w + 1);
    mid = x.size() / 2;
    if (w == 0 || w >= m) return x[mid];
    h   = (1 << w) - 1;
    acc = x[mid];
    for (int k = -h; k <= h; k++) acc += x[mid + k];
    return acc >> (w + 1);
  endfunction : model
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(9064));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK(touch_or_ready_alert_pin_n, 1'b1)
    bus(0, OFS_THR_BASE + THR_HI_OFS, 0);
    `CHK(q[11:0], THR_HI_RST)
    bus(0, 6'h3C, 0);
    `CHK(q, 32'h0000_0000)
    for (int c = 0; c < 16; c++) begin
      if (c[3:2] != 0 && c[1:0] == 3) continue;
      bus(1, OFS_CFG, 32'(c));
      n  = c[3:2] == 0 ? (c[1:0] == 0 ? 1 : 1 << (c[1:0] + 1)) : (1 << (c[3:2] + 1)) - 1;
      ch = 3'($urandom % 7);
      s.delete();
      for (int k = 0; k < n; k++) begin
        s.push_back(int'($urandom % 4096));
        i_src.q.push_back({ch, 12'(s[k])});
      end
      wait_res();
      e = 12'(model(int'(c[3:2]), int'(c[1:0]), s));
      `CHK(res_data, e)
      `CHK(res_chan, ch)
    end
    $display("test filter modes done");
    bus(1, OFS_CFG, 0);
    for (int k = 0; k < 3; k++) begin
      bus(1, 6'(OFS_THR_BASE + k * THR_STRIDE), 256);
      bus(1, 6'(OFS_THR_BASE + k * THR_STRIDE + THR_HI_OFS), 512);
    end
    for (int z = 0; z < 4; z++) begin
      bus(1, OFS_ZONE, 32'((z < 3 ? 7 : 0) | (z % 3) * 32'h0000_0150));
      for (int ci = 0; ci < 4; ci++) begin
        for (int vi = 0; vi < 6; vi++) begin
          v   = vals[vi];
          hit = z == 0 ? v >= 512 : z == 1 ? (v > 256 && v < 512) : z == 2 ? v <= 256 : 0;
          hit = hit && ci < 3;
          i_src.q.push_back({chs[ci], 12'(v)});
          wait_res();
          `CHK(touch_or_ready_alert_pin_n, !hit)
          bus(0, OFS_STATUS, 0);
          `CHK(q[2:0], hit ? 3'(1 << ci) : 3'h0)
          bus(1, OFS_STATUS, 7);
        end
      end
    end
    $display("test zone detection done");
    test_done();
  end
endmodule : tb_median_average_zone_filter

// ---- verilog/mazf_pkg.sv ----
// Package: constants, register map and state codes of the median/average zone filter
package mazf_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int unsigned DATA_W  = 12;
  localparam int unsigned DEPTH   = 16;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned CNT_W   = 5;
  localparam int unsigned SUM_W   = 17;
  localparam int unsigned NZONE   = 3;

  // ==========================================================================
  // Channel codes from the converter sequencer
  localparam logic [2:0] CH_X     = 3'h0;
  localparam logic [2:0] CH_Y     = 3'h1;
  localparam logic [2:0] CH_Z1    = 3'h2;
  localparam logic [2:0] CH_Z2    = 3'h3;
  localparam logic [2:0] CH_AUX   = 3'h4;
  localparam logic [2:0] CH_TSNGL = 3'h5;
  localparam logic [2:0] CH_TDIFF = 3'h6;

  // ==========================================================================
  // Filter size tables, indexed by the two-bit codes
  localparam logic [3:0][4:0] AVG_N   = {5'h10, 5'h08, 5'h04, 5'h01};
  localparam logic [3:0][2:0] AVG_SH  = {3'h4, 3'h3, 3'h2, 3'h0};
  localparam logic [3:0][3:0] MED_MID = {4'h7, 4'h3, 4'h1, 4'h0};
  localparam logic [3:0][3:0] HALF_W  = {4'h0, 4'h3, 4'h1, 4'h0};
  localparam logic [3:0][2:0] COMB_SH = {3'h0, 3'h3, 3'h2, 3'h0};

  // ==========================================================================
  // Zone select codes
  localparam logic [1:0] ZONE_HIGH = 2'h0;
  localparam logic [1:0] ZONE_MID  = 2'h1;
  localparam logic [1:0] ZONE_LOW  = 2'h2;

  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] OFS_CFG      = 6'h00;
  localparam logic [5:0] OFS_ZONE     = 6'h04;
  localparam logic [5:0] OFS_STATUS   = 6'h08;
  localparam logic [5:0] OFS_RESULT   = 6'h0C;
  localparam logic [5:0] OFS_THR_BASE = 6'h10;
  localparam logic [5:0] OFS_THR_LAST = 6'h24;
  localparam logic [5:0] THR_STRIDE   = 6'h08;
  localparam logic [5:0] THR_HI_OFS   = 6'h04;

  // ==========================================================================
  // Reset values
  localparam logic [3:0]        CFG_RST    = 4'h0;
  localparam logic [8:0]        ZONE_RST   = 9'h000;
  localparam logic [DATA_W-1:0] THR_LO_RST = 12'h000;
  localparam logic [DATA_W-1:0] THR_HI_RST = 12'hFFF;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PIV  = 5'b00010,
    ST_PLD  = 5'b00100,
    ST_CMP  = 5'b01000,
    ST_ACC  = 5'b10000
  } mazf_state_e;

  // Merge a bus write into an old value under byte enables
  function automatic logic [31:0] mazf_be_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : mazf_be_merge

endpackage : mazf_pkg

// ---- verilog/mazf_sample_buf.sv ----
// Sample buffer: one write port, one registered read port
`timescale 1ns/1ps
module mazf_sample_buf
  import mazf_pkg::*;
(
  input  wire logic                core_clk, // Clock
  input  wire logic                wr_en,    // Write strobe
  input  wire logic [ADDR_W-1:0]   wr_addr,  // Write index
  input  wire logic [DATA_W-1:0]   wr_data,  // Write value
  input  wire logic [ADDR_W-1:0]   rd_addr,  // Read index
  output logic      [DATA_W-1:0]   rd_data   // Read value, one cycle later
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : mazf_sample_buf

// ---- verilog/mazf_top.sv ----
// Median/average filter with zone detection and Avalon-MM register slave
// Notes on behaviour
// - Each result is filtered first, then the filtered value goes to zone detection.
// - Filter acts as median only, average only, or median then average.
// - The N collected results are ordered by value before selection.
// - Median size one and window one pass the single result unchanged.
// - Median one, window above one: average W results, N equals W.
// - Median above one, window one: output middle of M sorted results.
// - Both above one: average middle W of M, median counted twice.
// - Median code 00/01/10/11 selects M of 1, 3, 7, 15.
// - With M one, window code selects W of 1, 4, 8, 16.
// - With M above one, codes select W 1, 3, 7, and W below M.
// - Any invalid combination falls back to median only at programmed size.
// - The filter applies to every input: touch, both temperatures, auxiliary.
// - Zone detector keeps results meeting two-threshold condition and alerts.
// - Zones: at or above high, strictly between, at or below low.
// - Auxiliary and both temperatures have own thresholds and own enables.
// - Touch coordinate results never undergo zone comparison.
// - A zone hit drives the alert pin low and sets its ready flag.
`timescale 1ns/1ps
module mazf_top
  import mazf_pkg::*;
(
  input  wire logic                        core_clk,                   // 25 MHz clock
  input  wire logic                        rst_n,                      // Sync reset, low
  input  wire logic [5:0]                  avs_address,                // Byte address
  input  wire logic                        avs_read,                   // Read request
  input  wire logic                        avs_write,                  // Write request
  input  wire logic [31:0]                 avs_writedata,              // Write data
  input  wire logic [3:0]                  avs_byteenable,             // Byte lanes
  output logic      [31:0]                 avs_readdata,               // Read data
  output logic                             avs_waitrequest,            // Wait
  input  wire logic                        smp_valid,                  // Sample offered
  input  wire logic [mazf_pkg::DATA_W-1:0] smp_data,                   // Sample value
  input  wire logic [2:0]                  smp_chan,                   // Sample channel
  output logic                             smp_ready,                  // Sample taken
  output logic                             res_valid,                  // Result pulse
  output logic      [mazf_pkg::DATA_W-1:0] res_data,                   // Filtered result
  output logic      [2:0]                  res_chan,                   // Result channel
  output logic                             touch_or_ready_alert_pin_n  // Alert, low
);
  import mazf_pkg::*;
  default clocking cb_core @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Registers and state
  logic [1:0]              median_size, window_size;
  logic [NZONE-1:0]        zone_en;
  logic [NZONE-1:0][1:0]   zone_sel;
  logic [DATA_W-1:0]       thr_lo [NZONE];
  logic [DATA_W-1:0]       thr_hi [NZONE];
  logic [NZONE-1:0]        result_ready_flag;
  mazf_state_e             state;
  logic [CNT_W-1:0]        cnt;
  logic [CNT_W-1:0]        idx_i, idx_j;
  logic [3:0]              rank;
  logic [DATA_W-1:0]       pivot;
  logic [SUM_W-1:0]        sum;
  logic [2:0]              burst_chan;
  logic [CNT_W-1:0]        eff_n;
  logic [3:0]              eff_lo, eff_hi, eff_mid;
  logic                    eff_dbl;
  logic [2:0]              eff_sh;
  logic                    out_go;
  logic [DATA_W-1:0]       first_smp;
  // ==========================================================================
  // Effective filter configuration from the size codes
  logic [CNT_W-1:0] next_n;
  logic [3:0]       next_lo, next_hi, next_mid;
  logic             next_dbl;
  logic [2:0]       next_sh;
  always_comb begin
    next_mid = MED_MID[median_size];
    next_dbl = 1'b0;
    next_sh  = 3'h0;
    if (median_size == 2'h0) begin
      next_n  = AVG_N[window_size];
      next_lo = 4'h0;
      next_hi = 4'(next_n - 5'h01);
      next_sh = AVG_SH[window_size];
    end else begin
      next_n  = {next_mid, 1'b1};
      next_lo = next_mid;
      next_hi = next_mid;
      if (window_size != 2'h0 && window_size < median_size) begin
        next_lo  = next_mid - HALF_W[window_size];
        next_hi  = next_mid + HALF_W[window_size];
        next_dbl = 1'b1;
        next_sh  = COMB_SH[window_size];
      end
    end
  end
  // ==========================================================================
  // Sample buffer
  logic              accept, last_smp, less;
  logic [CNT_W-1:0]  n_cur;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  assign accept   = (state == ST_IDLE) && smp_valid && smp_ready;
  assign n_cur    = (cnt == 5'h00) ? next_n : eff_n;
  assign last_smp = (5'(cnt + 5'h01) == n_cur);
  assign rd_addr  = (state == ST_PIV) ? idx_i[ADDR_W-1:0] : idx_j[ADDR_W-1:0];
  // Ties break on index, so equal samples get distinct ranks
  assign less     = (rd_data < pivot) || ((rd_data == pivot) &&
                    (5'(idx_j - 5'h01) < idx_i));
  mazf_sample_buf u_buf (
    .core_clk (core_clk),
    .wr_en    (accept),
    .wr_addr  (cnt[ADDR_W-1:0]),
    .wr_data  (smp_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );
  // Latch the configuration at the first sample of each burst
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eff_n      <= 5'h01;
      eff_lo     <= 4'h0;
      eff_hi     <= 4'h0;
      eff_mid    <= 4'h0;
      eff_dbl    <= 1'b0;
      eff_sh     <= 3'h0;
      burst_chan <= CH_X;
      first_smp  <= 12'h000;
    end else if (accept && cnt == 5'h00) begin
      eff_n      <= next_n;
      eff_lo     <= next_lo;
      eff_hi     <= next_hi;
      eff_mid    <= next_mid;
      eff_dbl    <= next_dbl;
      eff_sh     <= next_sh;
      burst_chan <= smp_chan;
      first_smp  <= smp_data;
    end
  end
  // ==========================================================================
  // Rank each sample against all others, accumulate the selected ranks
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cnt       <= 5'h00;
      idx_i     <= 5'h00;
      idx_j     <= 5'h00;
      rank      <= 4'h0;
      pivot     <= 12'h000;
      sum       <= 17'h0_0000;
      smp_ready <= 1'b0;
      out_go    <= 1'b0;
    end else begin
      out_go <= 1'b0;
      case (state)
        ST_IDLE: begin
          smp_ready <= 1'b1;
          if (accept) begin
            cnt <= 5'(cnt + 5'h01);
            if (last_smp) begin
              smp_ready <= 1'b0;
              idx_i     <= 5'h00;
              sum       <= 17'h0_0000;
              state     <= ST_PIV;
            end
          end
        end
        ST_PIV: begin
          idx_j <= 5'h00;
          state <= ST_PLD;
        end
        ST_PLD: begin
          pivot <= rd_data;
          rank  <= 4'h0;
          idx_j <= 5'h01;
          state <= ST_CMP;
        end
        ST_CMP: begin
          rank  <= 4'(rank + {3'h0, less});
          idx_j <= 5'(idx_j + 5'h01);
          if (idx_j == eff_n) begin
            state <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (rank >= eff_lo && rank <= eff_hi) begin
            if (eff_dbl && rank == eff_mid) begin
              sum <= 17'(sum + {pivot, 1'b0});
            end else begin
              sum <= 17'(sum + {5'h00, pivot});
            end
          end
          if (idx_i == 5'(eff_n - 5'h01)) begin
            cnt       <= 5'h00;
            out_go    <= 1'b1;
            smp_ready <= 1'b1;
            state     <= ST_IDLE;
          end else begin
            idx_i <= 5'(idx_i + 5'h01);
            state <= ST_PIV;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ==========================================================================
  // Result, zone detection and alert
  logic [DATA_W-1:0] filt;
  logic [NZONE-1:0]  hit, flag_set, flag_clr, next_flag;
  assign filt = DATA_W'(sum >> eff_sh);
  generate
    for (genvar k = 0; k < NZONE; k++) begin : g_zone
      mazf_zone_det u_zone (
        .value  (filt),
        .thr_lo (thr_lo[k]),
        .thr_hi (thr_hi[k]),
        .zone   (zone_sel[k]),
        .hit    (hit[k])
      );
      // Touch channels never match a zone index
      assign flag_set[k] = out_go && zone_en[k] && hit[k] &&
                           (burst_chan == 3'(CH_AUX + k));
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          thr_lo[k] <= THR_LO_RST;
          thr_hi[k] <= THR_HI_RST;
        end else if (avs_write && !avs_waitrequest) begin
          if (avs_address == 6'(OFS_THR_BASE + k * THR_STRIDE)) begin
            thr_lo[k] <= DATA_W'(mazf_be_merge({20'h0_0000, thr_lo[k]},
                                               avs_writedata, avs_byteenable));
          end else if (avs_address == 6'(OFS_THR_BASE + k * THR_STRIDE + THR_HI_OFS)) begin
            thr_hi[k] <= DATA_W'(mazf_be_merge({20'h0_0000, thr_hi[k]},
                                               avs_writedata, avs_byteenable));
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_data  <= 12'h000;
      res_chan  <= CH_X;
    end else begin
      res_valid <= out_go;
      if (out_go) begin
        res_data <= filt;
        res_chan <= burst_chan;
      end
    end
  end
  // A new hit wins over a simultaneous write-one-to-clear
  assign flag_clr  = (avs_write && !avs_waitrequest && avs_address == OFS_STATUS &&
                      avs_byteenable[0]) ? avs_writedata[NZONE-1:0] : 3'h0;
  assign next_flag = (result_ready_flag & ~flag_clr) | flag_set;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_ready_flag          <= 3'h0;
      touch_or_ready_alert_pin_n <= 1'b1;
    end else begin
      result_ready_flag          <= next_flag;
      touch_or_ready_alert_pin_n <= ~|next_flag;
    end
  end
  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the answer
  logic [31:0] rd_mux;
  logic [5:0]  thr_ofs;
  logic [1:0]  thr_idx;
  assign thr_ofs = 6'(avs_address - OFS_THR_BASE);
  assign thr_idx = thr_ofs[4:3];
  always_comb begin
    if (avs_address == OFS_CFG) begin
      rd_mux = {28'h000_0000, median_size, window_size};
    end else if (avs_address == OFS_ZONE) begin
      rd_mux = {22'h00_0000, zone_sel, 1'b0, zone_en};
    end else if (avs_address == OFS_STATUS) begin
      rd_mux = {28'h000_0000, state != ST_IDLE, result_ready_flag};
    end else if (avs_address == OFS_RESULT) begin
      rd_mux = {17'h0_0000, res_chan, 12'(res_data)};
    end else if (avs_address >= OFS_THR_BASE && avs_address <= OFS_THR_LAST &&
                 avs_address[1:0] == 2'h0) begin
      rd_mux = {20'h0_0000, thr_ofs[2] ? thr_hi[thr_idx] : thr_lo[thr_idx]};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      median_size <= CFG_RST[3:2];
      window_size <= CFG_RST[1:0];
      zone_en     <= ZONE_RST[2:0];
      zone_sel    <= ZONE_RST[8:3];
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == OFS_CFG) begin
        median_size <= avs_writedata[3:2];
        window_size <= avs_writedata[1:0];
      end else if (avs_address == OFS_ZONE) begin
        zone_en     <= avs_writedata[2:0];
        zone_sel    <= {avs_writedata[9:8], avs_writedata[7:6], avs_writedata[5:4]};
      end
    end
  end
  // ==========================================================================
  // Assertions
  property p_busy_stall;
    (state != ST_IDLE) |-> !smp_ready;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("sample taken while busy");
  property p_bypass;
    (out_go && eff_n == 5'h01) |=> res_valid && res_data == $past(first_smp);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered the sample");
  property p_med7;
    (accept && cnt == 5'h00 && median_size == 2'h2 && window_size == 2'h0)
      |=> eff_n == 5'h07 && eff_lo == 4'h3 && eff_hi == 4'h3;
  endproperty
  a_med7: assert property (p_med7) else $error("median seven decoded wrong");
  property p_avg16;
    (accept && cnt == 5'h00 && median_size == 2'h0 && window_size == 2'h3)
      |=> eff_n == 5'h10 && eff_sh == 3'h4 && eff_hi == 4'hF;
  endproperty
  a_avg16: assert property (p_avg16) else $error("average sixteen decoded wrong");
  property p_fallback;
    (accept && cnt == 5'h00 && median_size == 2'h2 && window_size == 2'h2)
      |=> eff_n == 5'h07 && !eff_dbl && eff_sh == 3'h0;
  endproperty
  a_fallback: assert property (p_fallback) else $error("invalid combo not median only");
  property p_comb;
    (accept && cnt == 5'h00 && median_size == 2'h3 && window_size == 2'h2)
      |=> eff_lo == 4'h4 && eff_hi == 4'hA && eff_dbl && eff_sh == 3'h3;
  endproperty
  a_comb: assert property (p_comb) else $error("combined window decoded wrong");
  property p_touch_no_zone;
    (out_go && burst_chan < CH_AUX) |-> flag_set == 3'h0;
  endproperty
  a_touch_no_zone: assert property (p_touch_no_zone) else $error("touch hit a zone");
  property p_alert;
    (|flag_set) |=> !touch_or_ready_alert_pin_n && (result_ready_flag & $past(flag_set)) != 3'h0;
  endproperty
  a_alert: assert property (p_alert) else $error("zone hit without alert");
  property p_result_after_burst;
    res_valid |-> $past(out_go) && $past(state == ST_ACC, 2);
  endproperty
  a_result_after_burst: assert property (p_result_after_burst) else $error("early result");
  c_bypass: cover property (out_go && eff_n == 5'h01);
  c_comb:   cover property (out_go && eff_dbl);
  c_avg:    cover property (out_go && eff_n == 5'h10);
  c_alert:  cover property ($fell(touch_or_ready_alert_pin_n));
endmodule : mazf_top

// ---- verilog/mazf_zone_det.sv ----
// Zone comparator for one thresholded channel
`timescale 1ns/1ps
module mazf_zone_det
  import mazf_pkg::*;
(
  input  wire logic [DATA_W-1:0] value,  // Filtered result
  input  wire logic [DATA_W-1:0] thr_lo, // Low threshold
  input  wire logic [DATA_W-1:0] thr_hi, // High threshold
  input  wire logic [1:0]        zone,   // Zone select
  output logic                   hit     // Result lies in the zone
);
  always_comb begin
    case (zone)
      ZONE_HIGH: hit = (value >= thr_hi);
      ZONE_MID:  hit = (value > thr_lo) && (value < thr_hi);
      ZONE_LOW:  hit = (value <= thr_lo);
      default:   hit = 1'b0;
    endcase
  end
endmodule : mazf_zone_det
